// ### design/msc_sys_ctrl.sv
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "msc_regs.svh"
// Contract
// RL1 - Six-bit prescaler divides by 1 to 64
// RL2 - Counter decrements per prescaler overflow, 1-256
// RL3 - Timer request when both reach end
// RL4 - Start, stop, continue or reload commands
// RL5 - Single pass halts; continuous mode reloads
// RL6 - Counter readable undisturbed; prescaler not readable
// RL7 - Five sources: four pins, one timer
// RL8 - Global and per-source mask bits
// RL9 - Priority encoder set by priority register
// RL10 - Grant disables interrupts, then vectors
// RL11 - Vector is two bytes, 16-bit address
// RL12 - Requests recorded while masked for polling
// RL13 - Retriggerable watchdog resets device on terminal
// RL14 - Software refreshes watchdog within each period
// RL15 - Watchdog timeout is 294912 clock periods
// RL16 - Hot flag set by watchdog, read-clear
// RL17 - Bit five keeps watchdog running in HALT
// RL18 - Power-on one-shot 589824 clocks, bypass rule
// RL19 - HALT gates CPU clock; interrupts end it
// RL20 - STOP ended by falling row or host edge
// RL21 - Software issues NOP before STOP or HALT
// RL22 - Warm flag set on STOP entry, read-clear
module msc_sys_ctrl #(
  parameter int WDT_CYCLES = `MSC_WDT_CLKS,
  parameter int POR_CYCLES = `MSC_POR_CLKS,
  parameter bit WDT_MASK_EN = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [9:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  // Pins from outside
  input wire logic [3:0] extIntPin,
  input wire logic [7:0] rowPin,
  input wire logic hostDataPin,
  input wire logic powerGood,
  // CPU core side
  input wire logic cpuIntTake,
  input wire logic cpuWdtRefresh,
  input wire logic cpuHaltReq,
  input wire logic cpuStopReq,
  output logic cpuClkEn,
  output logic cpuRstHold,
  output logic intPending,
  output logic [15:0] vectorAddr,
  output logic [15:0] resumeAddr,
  output msc_pkg::msc_pwr_t pwrState
);
  import msc_pkg::*;

  localparam int WW = $clog2(WDT_CYCLES + 1);
  localparam int PW = $clog2(POR_CYCLES + 1);
  localparam bit POR_BYPASS = (`MSC_CLK_HZ == `MSC_POR_BYPASS_HZ);

  // Counters below need at least two states to mean anything
  if (WDT_CYCLES < 2 || POR_CYCLES < 2) begin : g_chk
    $error("msc_sys_ctrl: cycle counts below two");
  end

  // Address match against a register index
  function automatic logic isReg(input logic [9:0] a, input logic [7:0] idx);
    return a == {idx, 2'b00};
  endfunction : isReg

  // Rotating priority pick: search starts at the source named by prio
  function automatic logic [2:0] pickSrc(input logic [4:0] req, input logic [2:0] prio);
    logic [2:0] idx;
    logic [2:0] res;
    idx = (prio > 3'h4) ? 3'h0 : prio;
    res = idx;
    for (int k = 4; k >= 0; k--) begin
      if (req[(int'(idx) + k) % 5]) begin
        res = 3'((int'(idx) + k) % 5);
      end
    end
    return res;
  endfunction : pickSrc

  // Vector slot of a source: two bytes each from address zero
  function automatic logic [15:0] vecOf(input logic [2:0] src);
    return {12'h000, src, 1'b0};
  endfunction : vecOf

  msc_pwr_t pwrReg;
  msc_tctl_t tctlReg;
  msc_flags_t flagReg;
  logic [13:0] pinMeta;
  logic [13:0] pinSync;
  logic [13:0] pinLast;
  logic [5:0] preReg;
  logic [5:0] preCnt;
  logic [7:0] initReg;
  logic [7:0] cntReg;
  logic [7:0] imrReg;
  logic [2:0] iprReg;
  logic [2:0] pickReg;
  logic [4:0] reqVec;
  logic [4:0] srcEvt;
  logic [WW-1:0] wdtCnt;
  logic [PW-1:0] porCnt;
  logic waitReg;
  logic [7:0] rdMux;
  logic wrAcc;
  logic rdAcc;
  logic tick;
  logic preOvf;
  logic endCount;
  logic wdtRun;
  logic wdtFire;
  logic porDone;
  logic pgRise;
  logic sysRst;
  logic stopWake;
  logic [4:0] enReq;
  logic grant;

  // Pins cross into the clock domain; a third stage feeds edge detection
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta <= `MSC_PIN_RST;
      pinSync <= `MSC_PIN_RST;
      pinLast <= `MSC_PIN_RST;
    end else begin
      pinMeta <= {powerGood, hostDataPin, rowPin, extIntPin};
      pinSync <= pinMeta;
      pinLast <= pinSync;
    end
  end

  // Edge events from the synchronised pins
  assign pgRise = pinSync[13] & ~pinLast[13];
  assign stopWake = |(~pinSync[12:4] & pinLast[12:4]); // [RL20]
  assign sysRst = wdtFire | pgRise; // [RL13]

  // Bus handshake: one wait state, then the access is taken
  assign wrAcc = avsWrite & ~waitReg;
  assign rdAcc = avsRead & ~waitReg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitReg <= 1'b1;
    end else begin
      waitReg <= ~((avsRead | avsWrite) & waitReg);
    end
  end

  // Read data is captured while waitrequest is still high
  always_comb begin
    rdMux = 8'h00;
    if (isReg(avsAddress, `MSC_IDX_TCTL)) begin
      rdMux = {5'h00, tctlReg.cont, 1'b0, tctlReg.run};
    end else if (isReg(avsAddress, `MSC_IDX_TINIT)) begin
      rdMux = cntReg; // [RL6]
    end else if (isReg(avsAddress, `MSC_IDX_IPR)) begin
      rdMux = {5'h00, iprReg};
    end else if (isReg(avsAddress, `MSC_IDX_IRQ)) begin
      rdMux = {flagReg, reqVec}; // [RL12]
    end else if (isReg(avsAddress, `MSC_IDX_IMR)) begin
      rdMux = imrReg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avsReadData <= 32'h0000_0000;
    end else if (avsRead & waitReg) begin
      avsReadData <= {24'h000000, rdMux};
    end
  end

  // Power state; watchdog and power-good restart the one-shot
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwrReg <= PWR_POR;
    end else if (sysRst) begin
      pwrReg <= PWR_POR; // [RL18]
    end else begin
      unique case (pwrReg)
        PWR_POR: begin
          if (porDone) begin
            pwrReg <= PWR_RUN;
          end
        end
        PWR_RUN: begin
          if (cpuStopReq) begin
            pwrReg <= PWR_STOP;
          end else if (cpuHaltReq) begin
            pwrReg <= PWR_HALT;
          end
        end
        PWR_HALT: begin
          if (|enReq) begin
            pwrReg <= PWR_RUN; // [RL19]
          end
        end
        PWR_STOP: begin
          if (stopWake) begin
            pwrReg <= POR_BYPASS ? PWR_RUN : PWR_POR; // [RL18] [RL20]
          end
        end
      endcase
    end
  end

  // Power-on one-shot counter runs only in the reset hold state
  assign porDone = porCnt == PW'(POR_CYCLES - 1);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      porCnt <= '0;
    end else if (pwrReg != PWR_POR || sysRst) begin
      porCnt <= '0;
    end else if (!porDone) begin
      porCnt <= porCnt + PW'(1); // [RL18]
    end
  end

  // Watchdog: clocked by sys_clk, frozen in STOP, held at zero during the one-shot
  assign wdtRun = WDT_MASK_EN &&
    (pwrReg == PWR_RUN || (pwrReg == PWR_HALT && flagReg.wdHalt)); // [RL17]
  assign wdtFire = wdtRun && wdtCnt == WW'(WDT_CYCLES - 1); // [RL15]

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdtCnt <= '0;
    end else if (cpuWdtRefresh || wdtFire || pwrReg == PWR_POR) begin
      wdtCnt <= '0; // [RL13]
    end else if (wdtRun) begin
      wdtCnt <= wdtCnt + WW'(1);
    end
  end

  // Timer ticks every clock while running; no ticks in STOP or in the power-on hold
  assign tick = tctlReg.run && pwrReg != PWR_STOP && pwrReg != PWR_POR;
  assign preOvf = tick && preCnt == 6'h00; // [RL1]
  assign endCount = preOvf && cntReg == 8'h01; // [RL3]

  // Timer control, initial count and prescale registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tctlReg <= '0;
      preReg <= `MSC_PRE_RST;
      initReg <= `MSC_TINIT_RST;
    end else if (sysRst) begin
      tctlReg <= '0;
      preReg <= `MSC_PRE_RST;
      initReg <= `MSC_TINIT_RST;
    end else if (wrAcc && isReg(avsAddress, `MSC_IDX_TCTL)) begin
      tctlReg.run <= avsWriteData[`MSC_TCTL_RUN]; // [RL4]
      tctlReg.cont <= avsWriteData[`MSC_TCTL_CONT];
      tctlReg.load <= 1'b0;
    end else begin
      if (endCount && !tctlReg.cont) begin
        tctlReg.run <= 1'b0; // [RL5]
      end
      if (wrAcc && isReg(avsAddress, `MSC_IDX_PRE)) begin
        preReg <= avsWriteData[5:0];
      end
      if (wrAcc && isReg(avsAddress, `MSC_IDX_TINIT)) begin
        initReg <= avsWriteData[7:0];
      end
    end
  end

  // Prescaler counts N-1 down to 0; a code of zero divides by 64
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      preCnt <= 6'h3F;
    end else if (sysRst) begin
      preCnt <= 6'h3F;
    end else if (wrAcc && isReg(avsAddress, `MSC_IDX_TCTL) &&
                 avsWriteData[`MSC_TCTL_LOAD]) begin
      preCnt <= preReg - 6'h01; // [RL4]
    end else if (preOvf) begin
      preCnt <= preReg - 6'h01; // [RL1]
    end else if (tick) begin
      preCnt <= preCnt - 6'h01;
    end
  end

  // Down counter; an initial code of zero gives 256 counts
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cntReg <= 8'h00;
    end else if (sysRst) begin
      cntReg <= 8'h00;
    end else if (wrAcc && isReg(avsAddress, `MSC_IDX_TCTL) &&
                 avsWriteData[`MSC_TCTL_LOAD]) begin
      cntReg <= initReg; // [RL4]
    end else if (endCount) begin
      cntReg <= tctlReg.cont ? initReg : 8'h00; // [RL5]
    end else if (preOvf) begin
      cntReg <= cntReg - 8'h01; // [RL2]
    end
  end

  // Request sources: falling pin edges and the timer end of count
  assign srcEvt = {endCount, ~pinSync[3:0] & pinLast[3:0] &
                  {4{pwrReg != PWR_STOP}}}; // [RL7]
  assign enReq = reqVec & imrReg[4:0] & {5{imrReg[`MSC_IMR_GLOBAL]}}; // [RL8]
  assign grant = cpuIntTake && intPending;

  // One sticky request bit per source; a new event beats a grant or software clear
  for (genvar g = 0; g < 5; g++) begin : g_req
    logic bitReg;
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        bitReg <= 1'b0;
      end else if (sysRst) begin
        bitReg <= 1'b0;
      end else if (srcEvt[g]) begin
        bitReg <= 1'b1; // [RL12]
      end else if (grant && pickReg == 3'(g)) begin
        bitReg <= 1'b0;
      end else if (wrAcc && isReg(avsAddress, `MSC_IDX_IRQ)) begin
        bitReg <= avsWriteData[g];
      end
    end
    assign reqVec[g] = bitReg;
  end

  // Start flags: hot survives the watchdog reset, both clear on read
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flagReg <= '{hot: 1'b0, warm: 1'b0, wdHalt: `MSC_WDHALT_RST};
    end else begin
      if (wdtFire) begin
        flagReg.hot <= 1'b1; // [RL16]
      end else if (rdAcc && isReg(avsAddress, `MSC_IDX_IRQ) &&
                   avsReadData[`MSC_IRQ_HOT]) begin
        flagReg.hot <= 1'b0;
      end
      if (sysRst) begin
        flagReg.warm <= 1'b0; // [RL22]
      end else if (pwrReg == PWR_RUN && cpuStopReq) begin
        flagReg.warm <= 1'b1; // [RL22]
      end else if (rdAcc && isReg(avsAddress, `MSC_IDX_IRQ) &&
                   avsReadData[`MSC_IRQ_WARM]) begin
        flagReg.warm <= 1'b0;
      end
      if (sysRst) begin
        flagReg.wdHalt <= `MSC_WDHALT_RST;
      end else if (wrAcc && isReg(avsAddress, `MSC_IDX_IRQ)) begin
        flagReg.wdHalt <= avsWriteData[`MSC_IRQ_WDHALT]; // [RL17]
      end
    end
  end

  // Mask and priority registers; a grant drops the global enable
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      imrReg <= `MSC_IMR_RST;
      iprReg <= `MSC_IPR_RST;
    end else if (sysRst) begin
      imrReg <= `MSC_IMR_RST;
      iprReg <= `MSC_IPR_RST;
    end else begin
      if (grant) begin
        imrReg[`MSC_IMR_GLOBAL] <= 1'b0; // [RL10]
      end else if (wrAcc && isReg(avsAddress, `MSC_IDX_IMR)) begin
        imrReg <= avsWriteData[7:0]; // [RL8]
      end
      if (wrAcc && isReg(avsAddress, `MSC_IDX_IPR)) begin
        iprReg <= avsWriteData[2:0];
      end
    end
  end

  // Winner and request line to the CPU, one cycle behind the requests
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pickReg <= 3'h0;
      intPending <= 1'b0;
      vectorAddr <= 16'h0000;
    end else begin
      pickReg <= pickSrc(enReq, iprReg); // [RL9]
      intPending <= |enReq && pwrReg == PWR_RUN && !grant;
      vectorAddr <= vecOf(pickSrc(enReq, iprReg)); // [RL11]
    end
  end

  // Restart point after STOP: pending enabled vector, else fixed entry
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      resumeAddr <= `MSC_RESTART_ADDR;
    end else if (pwrReg == PWR_STOP && stopWake) begin
      resumeAddr <= |enReq ? vecOf(pickSrc(enReq, iprReg)) : `MSC_RESTART_ADDR; // [RL20]
    end
  end

  // CPU controls trail the power state by one clock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuClkEn <= 1'b0;
      cpuRstHold <= 1'b1;
      pwrState <= PWR_POR;
      avsWaitRequest <= 1'b1;
    end else begin
      cpuClkEn <= pwrReg == PWR_RUN; // [RL19]
      cpuRstHold <= pwrReg == PWR_POR; // [RL18]
      pwrState <= pwrReg;
      avsWaitRequest <= ~((avsRead | avsWrite) & waitReg);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_stop_entry;
    pwrReg == PWR_RUN && cpuStopReq && !sysRst;
  endsequence
  sequence s_stop_wake;
    pwrReg == PWR_STOP && stopWake && !sysRst;
  endsequence

  property p_pre_reload;
    preOvf && !sysRst && !wrAcc |=> preCnt == $past(preReg) - 6'h01;
  endproperty
  a_pre_reload: assert property (p_pre_reload) else $error("prescaler reload wrong"); // [RL1]
  property p_cnt_dec;
    preOvf && cntReg != 8'h01 && !sysRst && !wrAcc |=> cntReg == $past(cntReg) - 8'h01;
  endproperty
  a_cnt_dec: assert property (p_cnt_dec) else $error("counter did not step"); // [RL2]
  property p_timer_req;
    endCount && !sysRst |=> reqVec[4];
  endproperty
  a_timer_req: assert property (p_timer_req) else $error("timer request missing"); // [RL3]
  property p_single;
    endCount && !tctlReg.cont && !sysRst && !wrAcc |=> cntReg == 8'h00 && !tctlReg.run;
  endproperty
  a_single: assert property (p_single) else $error("single pass did not halt"); // [RL5]
  property p_read_keep;
    rdAcc && !preOvf && !sysRst |=> cntReg == $past(cntReg);
  endproperty
  a_read_keep: assert property (p_read_keep) else $error("read disturbed counter"); // [RL6]
  property p_mask;
    !imrReg[`MSC_IMR_GLOBAL] |=> !intPending;
  endproperty
  a_mask: assert property (p_mask) else $error("request passed global mask"); // [RL8]
  property p_grant;
    grant && !sysRst |=> !imrReg[`MSC_IMR_GLOBAL] && !intPending;
  endproperty
  a_grant: assert property (p_grant) else $error("grant left interrupts on"); // [RL10]
  property p_hot;
    wdtFire |=> flagReg.hot ##1 pwrReg == PWR_POR || pwrReg == PWR_RUN;
  endproperty
  a_hot: assert property (p_hot) else $error("hot flag not set"); // [RL16]
  property p_halt_exit;
    pwrReg == PWR_HALT && |enReq && !sysRst |=> pwrReg == PWR_RUN ##1 cpuClkEn;
  endproperty
  a_halt_exit: assert property (p_halt_exit) else $error("HALT not ended"); // [RL19]
  property p_stop_warm;
    s_stop_entry |=> flagReg.warm && pwrReg == PWR_STOP ##1 !cpuClkEn;
  endproperty
  a_stop_warm: assert property (p_stop_warm) else $error("STOP entry wrong"); // [RL22]
  property p_stop_wake;
    s_stop_wake |=> pwrReg == (POR_BYPASS ? PWR_RUN : PWR_POR);
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("STOP wake wrong"); // [RL20]
endmodule : msc_sys_ctrl

// ### design/msc_regs.svh
`ifndef MSC_REGS_SVH
`define MSC_REGS_SVH
// System clock rate in Hz
`define MSC_CLK_HZ 10000000
// Register indices; byte address is four times the index
`define MSC_IDX_TCTL 8'hF1
`define MSC_IDX_TINIT 8'hF2
`define MSC_IDX_PRE 8'hF3
`define MSC_IDX_IPR 8'hF9
`define MSC_IDX_IRQ 8'hFA
`define MSC_IDX_IMR 8'hFB
// Field positions
`define MSC_TCTL_RUN 0
`define MSC_TCTL_LOAD 1
`define MSC_TCTL_CONT 2
`define MSC_IRQ_WDHALT 5
`define MSC_IRQ_WARM 6
`define MSC_IRQ_HOT 7
`define MSC_IMR_GLOBAL 7
// Reset values
`define MSC_IMR_RST 8'h00
`define MSC_IPR_RST 3'h0
`define MSC_PRE_RST 6'h00
`define MSC_TINIT_RST 8'h00
`define MSC_WDHALT_RST 1'b1
`define MSC_PIN_RST 14'h3FFF
// Timing: watchdog and power-on one-shot last N / f seconds
`define MSC_WDT_DIV 294912
`define MSC_POR_DIV 589824
`define MSC_WDT_CLKS (`MSC_WDT_DIV)
`define MSC_POR_CLKS (`MSC_POR_DIV)
`define MSC_POR_BYPASS_HZ 4000000
// Program memory addresses
`define MSC_RESTART_ADDR 16'h000C
`endif

// ### design/msc_pkg.sv
package msc_pkg;
  // Power and execution state
  typedef enum logic [1:0] {PWR_POR, PWR_RUN, PWR_HALT, PWR_STOP} msc_pwr_t;
  // Timer control word, bit order as in the register
  typedef struct packed {
    logic cont;
    logic load;
    logic run;
  } msc_tctl_t;
  // Upper flags of the interrupt request register
  typedef struct packed {
    logic hot;
    logic warm;
    logic wdHalt;
  } msc_flags_t;
endpackage : msc_pkg

// ### tb/msc_pin_model.sv
`timescale 1ns/1ps
module msc_pin_model (
  // Clock
  input wire logic sys_clk,
  // One bit per line: host, row 7:0, ext 3:0
  input wire logic [12:0] fallReq,
  // Lines toward the block
  output logic [3:0] extIntPin,
  output logic [7:0] rowPin,
  output logic hostDataPin
);
  logic [12:0] lowMask = 13'h0000;
  int holdCnt = 0;
  // Hold a line low long enough to pass the two-flop synchroniser
  always @(posedge sys_clk) begin
    if (fallReq != 13'h0000) begin
      lowMask <= fallReq;
      holdCnt <= 6;
    end else if (holdCnt > 0) begin
      holdCnt <= holdCnt - 1;
    end else begin
      lowMask <= 13'h0000;
    end
  end
  // Released lines go back to the pull-up level
  assign {hostDataPin, rowPin, extIntPin} = ~lowMask;
endmodule : msc_pin_model

// ### tb/test_mcu_system_control_timer_irq_wdt.sv
`timescale 1ns/1ps
`include "msc_regs.svh"
module test_mcu_system_control_timer_irq_wdt;
  import msc_pkg::*;
  localparam int WDT = 40;
  localparam int POR = 20;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] avsAddress = 10'h000;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWriteData = 32'h00000000;
  logic [31:0] avsReadData;
  logic avsWaitRequest;
  logic [3:0] extIntPin;
  logic [7:0] rowPin;
  logic hostDataPin;
  logic powerGood = 1'b1;
  logic cpuIntTake = 1'b0;
  logic cpuWdtRefresh = 1'b0;
  logic cpuHaltReq = 1'b0;
  logic cpuStopReq = 1'b0;
  logic cpuClkEn;
  logic cpuRstHold;
  logic intPending;
  logic [15:0] vectorAddr;
  logic [15:0] resumeAddr;
  msc_pwr_t pwrState;
  logic [12:0] fallReq = 13'h0000;
  logic autoRefresh = 1'b1;
  int num_errors = 0;
  int n_checks = 0;
  int refreshCnt = 0;
  logic [7:0] rd;
  logic [7:0] v1;
  logic [7:0] v2;
  int c1;
  int c2;
  logic [7:0] tp [6] = '{8'h03, 8'h03, 8'h00, 8'h00, 8'h01, 8'h01};
  logic [7:0] ti [6] = '{8'h04, 8'h08, 8'h01, 8'h02, 8'h80, 8'h00};
  int td [3] = '{12, 64, 128};
  int vexp [4] = '{4, 6, 0, 2};
  logic [12:0] wake [2] = '{13'h0080, 13'h1000};

  msc_sys_ctrl #(.WDT_CYCLES(WDT), .POR_CYCLES(POR), .WDT_MASK_EN(1'b1)) msc_sys_ctrl_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .extIntPin(extIntPin), .rowPin(rowPin),
    .hostDataPin(hostDataPin), .powerGood(powerGood), .cpuIntTake(cpuIntTake),
    .cpuWdtRefresh(cpuWdtRefresh), .cpuHaltReq(cpuHaltReq), .cpuStopReq(cpuStopReq),
    .cpuClkEn(cpuClkEn), .cpuRstHold(cpuRstHold), .intPending(intPending),
    .vectorAddr(vectorAddr), .resumeAddr(resumeAddr), .pwrState(pwrState));
  msc_pin_model msc_pin_model_i (.sys_clk(sys_clk), .fallReq(fallReq),
    .extIntPin(extIntPin), .rowPin(rowPin), .hostDataPin(hostDataPin));

  // 10 MHz system clock
  always #50 sys_clk = ~sys_clk;
  // Software refresh every 16 clocks, only while the CPU runs
  always @(posedge sys_clk) begin
    refreshCnt <= refreshCnt + 1;
    cpuWdtRefresh <= autoRefresh && pwrState === PWR_RUN && refreshCnt % 16 == 0;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: %s got %0h expected %0h", $time, msg, got, exp);
      num_errors++;
    end
  endtask : check
  function automatic bit cond(input int sel);
    case (sel)
      0: return intPending === 1'b1;
      1: return cpuClkEn === 1'b1;
      2: return pwrState === PWR_POR;
      3: return pwrState === PWR_HALT;
      4: return pwrState === PWR_STOP;
      5: return pwrState === PWR_RUN;
      default: return cpuWdtRefresh === 1'b1;
    endcase
  endfunction : cond
  // Counts falling edges until the condition holds; a stuck wait ends the run
  task automatic wait_until(input int sel, input int lim, output int cyc);
    cyc = 0;
    do begin
      @(negedge sys_clk);
      cyc++;
      if (cyc > lim) begin
        $display("wrong value at %0t: wait %0d timed out", $time, sel);
        num_errors++;
        results();
      end
    end while (!cond(sel));
  endtask : wait_until
  // Request held until the edge that sees waitrequest low; data taken there
  task automatic bus_xfer(input bit wr, input logic [7:0] idx, input logic [7:0] d,
                          output logic [7:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avsAddress <= {idx, 2'b00};
    avsWriteData <= {24'h000000, d};
    avsWrite <= wr;
    avsRead <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
      if (n > 20) begin
        $display("wrong value at %0t: bus stuck", $time);
        num_errors++;
        results();
      end
    end while (avsWaitRequest !== 1'b0);
    q = avsReadData[7:0];
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask : bus_xfer
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus_xfer(1'b1, idx, d, rd);
  endtask : wr
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input string msg);
    bus_xfer(1'b0, idx, 8'h00, rd);
    check(32'(rd), 32'(exp), msg);
  endtask : rdc
  // One-cycle CPU strobes, raised only between whole instructions
  task automatic cpu_pulse(input int which);
    @(posedge sys_clk);
    case (which)
      0: cpuIntTake <= 1'b1;
      1: cpuHaltReq <= 1'b1;
      default: cpuStopReq <= 1'b1;
    endcase
    @(posedge sys_clk);
    {cpuIntTake, cpuHaltReq, cpuStopReq} <= 3'b000;
  endtask : cpu_pulse
  task automatic pin_fall(input logic [12:0] m);
    @(posedge sys_clk);
    fallReq <= m;
    @(posedge sys_clk);
    fallReq <= 13'h0000;
  endtask : pin_fall
  // Single pass run; cycles from start to the timer request
  task automatic timer_time(input logic [7:0] pre, input logic [7:0] init, output int cyc);
    wr(`MSC_IDX_IRQ, 8'h20);
    wr(`MSC_IDX_IMR, 8'h90);
    wr(`MSC_IDX_PRE, pre);
    wr(`MSC_IDX_TINIT, init);
    wr(`MSC_IDX_TCTL, 8'h03);
    wait_until(0, 20000, cyc);
    rdc(`MSC_IDX_TCTL, 8'h00, "single pass stop");
    rdc(`MSC_IDX_TINIT, 8'h00, "count at end");
  endtask : timer_time

  // Main sequence; each block ends with a one-line note
  initial begin
    repeat (16) @(posedge sys_clk);
    check(32'({cpuRstHold, pwrState}), 32'({1'b1, PWR_POR}), "reset outputs");
    rst_n <= 1'b1;
    wait_until(1, POR + 20, c1);
    check(32'(c1 >= POR && c1 <= POR + 4), 1, "power-on hold length");
    rdc(`MSC_IDX_IMR, 8'h00, "mask reset");
    rdc(`MSC_IDX_IRQ, 8'h20, "request reset");
    wr(8'h10, 8'h55);
    rdc(8'h10, 8'h00, "unmapped reads zero");
    $display("test reset done");
    // Stop, read twice, continue, reload, continuous
    wr(`MSC_IDX_PRE, 8'h10);
    wr(`MSC_IDX_TINIT, 8'h64);
    wr(`MSC_IDX_TCTL, 8'h03);
    repeat (200) @(posedge sys_clk);
    wr(`MSC_IDX_TCTL, 8'h00);
    bus_xfer(1'b0, `MSC_IDX_TINIT, 8'h00, v1);
    rdc(`MSC_IDX_TINIT, v1, "read leaves count");
    check(32'(v1 < 8'h64 && v1 > 8'h50), 1, "count stepped");
    rdc(`MSC_IDX_PRE, 8'h00, "prescale hidden");
    wr(`MSC_IDX_TCTL, 8'h01);
    repeat (160) @(posedge sys_clk);
    wr(`MSC_IDX_TCTL, 8'h00);
    bus_xfer(1'b0, `MSC_IDX_TINIT, 8'h00, v2);
    check(32'(v2 < v1 && v2 > v1 - 8'h10), 1, "continue from held count");
    wr(`MSC_IDX_TCTL, 8'h02);
    rdc(`MSC_IDX_TINIT, 8'h64, "reload");
    wr(`MSC_IDX_PRE, 8'h01);
    wr(`MSC_IDX_TINIT, 8'h04);
    wr(`MSC_IDX_TCTL, 8'h07);
    repeat (50) @(posedge sys_clk);
    rdc(`MSC_IDX_TCTL, 8'h05, "continuous keeps running");
    wr(`MSC_IDX_TCTL, 8'h00);
    $display("test counter done");
    // Period differences cancel fixed latency: N times the count change
    for (int k = 0; k < 3; k++) begin
      timer_time(tp[2 * k], ti[2 * k], c1);
      timer_time(tp[2 * k + 1], ti[2 * k + 1], c2);
      check(32'(c2 - c1), 32'(td[k]), "timer period");
    end
    $display("test timer done");
    // Masked requests recorded, then granted by rotating priority
    wr(`MSC_IDX_IMR, 8'h00);
    wr(`MSC_IDX_IRQ, 8'h20);
    pin_fall(13'h0004);
    repeat (5) @(posedge sys_clk);
    rdc(`MSC_IDX_IRQ, 8'h24, "masked request recorded");
    check(32'(intPending), 0, "masked no pending");
    pin_fall(13'h000F);
    repeat (5) @(posedge sys_clk);
    wr(`MSC_IDX_IPR, 8'h02);
    wr(`MSC_IDX_IMR, 8'h80);
    repeat (2) @(negedge sys_clk);
    check(32'(intPending), 0, "per-source mask");
    for (int k = 0; k < 4; k++) begin
      wr(`MSC_IDX_IMR, 8'h8F);
      wait_until(0, 20, c1);
      check(32'(vectorAddr), 32'(vexp[k]), "vector");
      cpu_pulse(0);
      rdc(`MSC_IDX_IMR, 8'h0F, "grant clears global");
      check(32'(intPending), 0, "grant drops pending");
    end
    rdc(`MSC_IDX_IRQ, 8'h20, "grants cleared requests");
    $display("test interrupts done");
    // Watchdog fires only once refreshes stop
    check(32'(pwrState), 32'(PWR_RUN), "refreshed watchdog quiet");
    wait_until(6, 40, c1);
    autoRefresh = 1'b0;
    wait_until(2, WDT + 20, c1);
    check(32'(c1 >= WDT - 2 && c1 <= WDT + 4), 1, "watchdog period");
    check(32'(cpuRstHold), 1, "watchdog restarts hold");
    autoRefresh = 1'b1;
    wait_until(5, POR + 20, c1);
    rdc(`MSC_IDX_IRQ, 8'hA0, "hot flag");
    rdc(`MSC_IDX_IRQ, 8'h20, "hot clears on read");
    $display("test watchdog done");
    // HALT: watchdog on by default, off when bit 5 cleared
    cpu_pulse(1);
    wait_until(3, 10, c1);
    repeat (2) @(negedge sys_clk);
    check(32'(cpuClkEn), 0, "halt gates cpu clock");
    wait_until(2, WDT + 20, c1);
    check(32'(c1 <= WDT + 4), 1, "watchdog runs in halt");
    wait_until(5, POR + 20, c1);
    rdc(`MSC_IDX_IRQ, 8'hA0, "hot after halt timeout");
    for (int k = 0; k < 2; k++) begin
      wr(`MSC_IDX_IRQ, 8'h00);
      wr(`MSC_IDX_IMR, (k == 0) ? 8'h81 : 8'h90);
      if (k == 1) begin
        wr(`MSC_IDX_PRE, 8'h01);
        wr(`MSC_IDX_TINIT, 8'h1E);
        wr(`MSC_IDX_TCTL, 8'h03);
      end
      cpu_pulse(1);
      wait_until(3, 10, c1);
      if (k == 0) begin
        repeat (3 * WDT) @(posedge sys_clk);
        check(32'(pwrState), 32'(PWR_HALT), "watchdog idle in halt");
        pin_fall(13'h0001);
      end
      wait_until(5, 100, c1);
    end
    $display("test halt done");
    // STOP: row line, then host line, wake through power-on hold
    for (int k = 0; k < 2; k++) begin
      wr(`MSC_IDX_IRQ, k ? 8'h21 : 8'h20);
      wr(`MSC_IDX_IMR, k ? 8'h81 : 8'h00);
      cpu_pulse(2);
      wait_until(4, 10, c1);
      pin_fall(wake[k]);
      wait_until(2, 20, c1);
      check(32'(resumeAddr), k ? 32'h0 : 32'(`MSC_RESTART_ADDR), "restart point");
      wait_until(5, POR + 20, c1);
      check(32'(c1 >= POR), 1, "no bypass at this clock");
      bus_xfer(1'b0, `MSC_IDX_IRQ, 8'h00, rd);
      check(32'(rd & 8'h40), 32'h40, "warm flag");
      bus_xfer(1'b0, `MSC_IDX_IRQ, 8'h00, rd);
      check(32'(rd & 8'h40), 32'h00, "warm clears on read");
    end
    powerGood <= 1'b0;
    repeat (4) @(posedge sys_clk);
    powerGood <= 1'b1;
    wait_until(2, 10, c1);
    $display("test stop done");
    results();
  end
endmodule : test_mcu_system_control_timer_irq_wdt
